// ---- tb/dpoc_board.sv ----
// board logic model seen by the pins
`default_nettype none
module dpoc_board (
  input  wire logic [3:0] pin_out_i,
  input  wire logic [3:0] pin_oe_n_i,
  output wire logic [3:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // board pull-up sets the level of any released pin
  assign level_o = (pin_out_i & ~pin_oe_n_i) | pin_oe_n_i;
endmodule // dpoc_board
`default_nettype wire

// ---- tb/dpoc_pin_props.sv ----
// port-level assertions for the definable pin block
`default_nettype none
module dpoc_pin_props (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [3:0]  port_power_down_i,
  input wire logic [3:0]  pin_out_o,
  input wire logic [3:0]  pin_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // handshake shorthands; one clock domain, so defaults are shared
  wire aw_go = s_axi_awvalid_i && s_axi_awready_o;
  wire w_go  = s_axi_wvalid_i && s_axi_wready_o;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  property p_bl; aw_go && w_go |-> ##2 s_axi_bvalid_o; endproperty
  a_bl: assert property (p_bl) else $error("write answer late");
  property p_bh; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_bk; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_bk: assert property (p_bk) else $error("second write taken");
  property p_bc; s_axi_bvalid_o |-> !s_axi_bresp_o[0]; endproperty
  a_bc: assert property (p_bc) else $error("bad write code");
  property p_rl; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rl: assert property (p_rl) else $error("read answer late");
  property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rh: assert property (p_rh) else $error("read data moved");
  property p_rk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_rk: assert property (p_rk) else $error("second read taken");
  property p_pd; (port_power_down_i == 4'hF) [*5] |-> &(pin_oe_n_o | pin_out_o); endproperty
  a_pd: assert property (p_pd) else $error("pin low in power down");
  c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
  c_pd: cover property (port_power_down_i != 4'h0);
endmodule // dpoc_pin_props
////////////////////////////////////////////////////////////////
bind dpoc_pin_ctrl dpoc_pin_props dpoc_pin_props_inst (.*);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the definable pin block
`include "dpoc_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ok = `DPOC_RESP_OKAY;
  logic clk_sys_i, rst_i, global_reset_i, l0;
  logic [3:0] port_power_down_i, port_enable_i, tx_packet_i, s_axi_wstrb_i, level;
  logic [3:0] pin_out_o, pin_oe_n_o;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, d;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [3:0] codes [4] = '{4'h0, 4'hF, 4'hD, 4'hE};
  int bad_count, comparisons, cyc, n;
  dpoc_pin_ctrl dpoc_pin_ctrl_inst (.*);
  dpoc_board dpoc_board_inst (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .level_o(level));
  ////////////////////////////////////////////////////////////////
  // control word: output direction always set
  function logic [31:0] mk(input logic [2:0] f, input logic [1:0] p, input logic na, oc,
                           input logic [3:0] led, input logic [5:0] phy);
    return {14'h0, phy, led, oc, na, p, 1'b1, f};
  endfunction
  // expected led pin: fixed codes give a level, activity codes toggle per packet
  function logic lvl(input logic [3:0] c, input logic s, input int p);
    return (c == `DPOC_LED_HIGH) ? 1'b1 : (c == `DPOC_LED_LOW) ? 1'b0 : s ^ p[0];
  endfunction
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task settle();
    repeat (6) @(posedge clk_sys_i);
  endtask
  // axi write; address and data released one by one as taken
  task wr(input logic [31:0] a, dt, input logic [1:0] e);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= dt;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk(s_axi_bresp_o, e);
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [31:0] a, ed, input logic [1:0] e);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk({s_axi_rresp_o, s_axi_rdata_o}, {e, ed});
    @(posedge clk_sys_i);
  endtask
  task give_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    port_enable_i = 4'hF;
    s_axi_wstrb_i = 4'hF;
    {global_reset_i, port_power_down_i, tx_packet_i, s_axi_awaddr_i, s_axi_wdata_i,
     s_axi_araddr_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i,
     s_axi_rready_i} = '0;
    d = $urandom(85);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    // control words keep only their defined fields; unmapped place reads zero, write refused
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      wr(i * 4, d, ok);
      rd(i * 4, d & `DPOC_CTL_MASK, ok);
    end
    rd(32'h100, 32'h0, `DPOC_RESP_SLVERR);
    wr(32'h100, d, `DPOC_RESP_SLVERR);
    // pin 0 marked global but owned by port 1; flag has no effect
    wr(0, mk(`DPOC_FUNC_PLAIN, 2'h1, 1'b1, 1'b0, 4'h0, 6'h0), ok);
    wr(`DPOC_OFF_SET, 32'h1, ok);
    settle();
    chk({pin_oe_n_o[0], level[0]}, 2'b01);
    port_power_down_i <= 4'h2;
    settle();
    chk({pin_oe_n_o[0], level[0]}, 2'b11);
    wr(0, mk(`DPOC_FUNC_PLAIN, 2'h1, 1'b1, 1'b1, 4'h0, 6'h0), ok);
    settle();
    chk({pin_oe_n_o[0], level[0]}, 2'b01);
    // every port down: no pin may sit driven low, whatever its mode
    port_power_down_i <= 4'hF;
    settle();
    chk(level, 4'hF);
    port_power_down_i <= 4'h0;
    wr(0, mk(`DPOC_FUNC_PLAIN, 2'h1, 1'b1, 1'b0, 4'h0, 6'h0), ok);
    global_reset_i <= 1'b1;
    settle();
    chk(pin_out_o[0], 1'b0);
    global_reset_i <= 1'b0;
    settle();
    chk(pin_out_o[0], 1'b1);
    port_enable_i <= 4'hD;
    n = 0;
    repeat (8) @(posedge clk_sys_i) if (pin_out_o[0] === 1'b0) n = 1;
    chk(n, 1);
    settle();
    chk(pin_out_o[0], 1'b1);
    // pin 1 in led function on port 2: fixed levels, then activity toggles
    foreach (codes[k])
    begin
      wr(4, mk(`DPOC_FUNC_LED, 2'h2, 1'b0, 1'b0, codes[k], `DPOC_PHY_GENERAL), ok);
      settle();
      l0 = pin_out_o[1];
      n = $urandom % 4 + 1;
      repeat (n)
      begin
        tx_packet_i <= 4'h4;
        repeat (3) @(posedge clk_sys_i);
        tx_packet_i <= 4'h0;
        repeat (3) @(posedge clk_sys_i);
      end
      settle();
      chk({pin_oe_n_o[1], pin_out_o[1]}, {1'b0, lvl(codes[k], l0, n)});
    end
    // led function needs the general physical id; any other id releases the pin
    wr(4, mk(`DPOC_FUNC_LED, 2'h2, 1'b0, 1'b0, `DPOC_LED_HIGH, 6'h0), ok);
    settle();
    chk(pin_oe_n_o[1], 1'b1);
    rd(`DPOC_OFF_PORTST, 32'h00000D00, ok);
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ---- verilog/dpoc_map.vh ----
// register offsets, field positions and constants for the definable pin block
`ifndef DPOC_MAP_VH
`define DPOC_MAP_VH
`define DPOC_NPINS         4
`define DPOC_NPORTS        4
// register byte offsets
`define DPOC_OFF_CTL0      12'h000
`define DPOC_OFF_SET       12'h010
`define DPOC_OFF_PORTST    12'h014
`define DPOC_OFF_PINST     12'h018
// pin control field positions
`define DPOC_FUNC_LSB      0
`define DPOC_FUNC_MSB      2
`define DPOC_DIR_BIT       3
`define DPOC_PORT_LSB      4
`define DPOC_PORT_MSB      5
`define DPOC_NA_BIT        6
`define DPOC_OUTCTL_BIT    7
`define DPOC_LED_LSB       8
`define DPOC_LED_MSB       11
`define DPOC_PHY_LSB       12
`define DPOC_PHY_MSB       17
`define DPOC_CTL_MASK      32'h0003FFFF
// codes
`define DPOC_FUNC_PLAIN    3'h0
`define DPOC_FUNC_LED      3'h1
`define DPOC_PHY_GENERAL   6'h3F
`define DPOC_LED_LOW       4'h0
`define DPOC_LED_HIGH      4'hF
`define DPOC_LED_MACACT    4'hD
`define DPOC_LED_FILTACT   4'hE
// reset values
`define DPOC_CTL_RST       32'h00000000
`define DPOC_SET_RST       32'h00000000
// glitch length during port enable or disable transition
`define DPOC_GLITCH_NS     10
`define DPOC_CLK_MHZ       200
`define DPOC_GLITCH_CYC    ((`DPOC_GLITCH_NS * `DPOC_CLK_MHZ + 999) / 1000)
// axi responses
`define DPOC_RESP_OKAY     2'h0
`define DPOC_RESP_SLVERR   2'h2
`endif

// ---- verilog/dpoc_pin_ctrl.v ----
// definable pin output control with axi4-lite register slave
//
// Summary of operation
// R1 - plain pin code with output direction makes the pin a software-definable output
// R2 - software sets port-independent flag on pins not tied to a port
// R3 - global pin should follow the set register; affected silicon ignores the flag
// R4 - owner port powered down: tri-state or drive high per undriven control
// R5 - undriven control clear: brief high-to-low glitch during global reset
// R6 - same glitch when the owner port is enabled or disabled
// R7 - software sets undriven control for outputs that must stay high in reset
// R8 - general pin in led function drives constant level from pattern code
// R9 - second fixed pattern code drives the opposite level
// R10 - activity patterns toggle pin on transmit packets even with link down
// R11 - pin returns to programmed level after reset or port transition ends
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "dpoc_map.vh"
`default_nettype none
module dpoc_pin_ctrl (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        global_reset_i,
  input  wire [3:0]  port_power_down_i,
  input  wire [3:0]  port_enable_i,
  input  wire [3:0]  tx_packet_i,
  input  wire [31:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [31:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output reg  [3:0]  pin_out_o,
  output reg  [3:0]  pin_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pin-level inputs
  reg [3:0]  pd_s1, pd_s2, en_s1, en_s2, tx_s1, tx_s2, tx_s3, en_s3;
  reg        gr_s1, gr_s2;

  // two flops before anything reads these; third stage only for edges
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pd_s1 <= 4'h0;
      pd_s2 <= 4'h0;
      en_s1 <= 4'h0;
      en_s2 <= 4'h0;
      en_s3 <= 4'h0;
      tx_s1 <= 4'h0;
      tx_s2 <= 4'h0;
      tx_s3 <= 4'h0;
      gr_s1 <= 1'b0;
      gr_s2 <= 1'b0;
    end
    else
    begin
      pd_s1 <= port_power_down_i;
      pd_s2 <= pd_s1;
      en_s1 <= port_enable_i;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      tx_s1 <= tx_packet_i;
      tx_s2 <= tx_s1;
      tx_s3 <= tx_s2;
      gr_s1 <= global_reset_i;
      gr_s2 <= gr_s1;
    end
  end

  // edge stages leave reset at zero while a port may already be enabled;
  // detection waits for real samples, so no false edge is seen and no real change is lost
  reg [2:0]  edge_arm;
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      edge_arm <= 3'h0;
    else
      edge_arm <= {edge_arm[1:0], 1'b1};
  end

  wire [3:0] en_edge = (en_s2 ^ en_s3) & {4{edge_arm[2]}};
  wire [3:0] tx_rise = tx_s2 & ~tx_s3;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite register slave
  reg [31:0] ctl [0:3];
  reg [31:0] set_reg;
  reg [31:0] aw_addr;
  reg        aw_held, w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire [11:0] wa = aw_addr[11:0];
  wire        do_write = aw_held & w_held & ~s_axi_bvalid_o;
  wire        wa_ctl = (wa[11:4] == 8'h00) & (wa[1:0] == 2'h0);
  wire        wa_set = (wa == `DPOC_OFF_SET);

  function [31:0] dpoc_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer      b;
    begin
      dpoc_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (st[b])
          dpoc_merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // address and data taken in either order, response after both
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `DPOC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      set_reg <= `DPOC_SET_RST;
      ctl[0]  <= `DPOC_CTL_RST;
      ctl[1]  <= `DPOC_CTL_RST;
      ctl[2]  <= `DPOC_CTL_RST;
      ctl[3]  <= `DPOC_CTL_RST;
    end
    else
    begin
      if (s_axi_awvalid_i & s_axi_awready_o)
      begin
        aw_addr <= s_axi_awaddr_i;
        aw_held <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o)
      begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        w_held <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (wa_ctl | wa_set) ? `DPOC_RESP_OKAY : `DPOC_RESP_SLVERR;
        if (wa_ctl)
          ctl[wa[3:2]] <= dpoc_merge(ctl[wa[3:2]], w_data, w_strb) & `DPOC_CTL_MASK;
        if (wa_set)
          set_reg <= dpoc_merge(set_reg, w_data, w_strb) & 32'h0000000F;
      end
      if (s_axi_bvalid_o & s_axi_bready_i)
      begin
        s_axi_bvalid_o  <= 1'b0;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data, status words live
  reg [31:0] next_rdata;
  reg [1:0]  next_rresp;
  wire [11:0] ra = s_axi_araddr_i[11:0];
  always @*
  begin
    next_rdata = 32'h0;
    next_rresp = `DPOC_RESP_OKAY;
    if ((ra[11:4] == 8'h00) & (ra[1:0] == 2'h0))
      next_rdata = ctl[ra[3:2]];
    else if (ra == `DPOC_OFF_SET)
      next_rdata = set_reg;
    else if (ra == `DPOC_OFF_PORTST)
      next_rdata = {20'h0, en_s2, pd_s2, 3'h0, gr_s2};
    else if (ra == `DPOC_OFF_PINST)
      next_rdata = {24'h0, pin_oe_n_o, pin_out_o};
    else
      next_rresp = `DPOC_RESP_SLVERR;
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= `DPOC_RESP_OKAY;
    end
    else if (s_axi_arvalid_i & s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end
    else if (s_axi_rvalid_o & s_axi_rready_i)
    begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin output logic
  // glitch length cut to the counter width on purpose; the count is small
  wire [31:0] glitch_len = `DPOC_GLITCH_CYC;

  genvar g;
  generate
    for (g = 0; g < `DPOC_NPINS; g = g + 1)
    begin : pin
      wire [31:0] c      = ctl[g];
      wire [2:0]  func   = c[`DPOC_FUNC_MSB:`DPOC_FUNC_LSB];
      wire        dir    = c[`DPOC_DIR_BIT];
      wire [1:0]  port   = c[`DPOC_PORT_MSB:`DPOC_PORT_LSB];
      wire        outctl = c[`DPOC_OUTCTL_BIT];
      wire [3:0]  led    = c[`DPOC_LED_MSB:`DPOC_LED_LSB];
      wire [5:0]  phy    = c[`DPOC_PHY_MSB:`DPOC_PHY_LSB];
      wire        is_sdp = (func == `DPOC_FUNC_PLAIN) & dir;                   // [R1]
      wire        is_led = (func == `DPOC_FUNC_LED) & (phy == `DPOC_PHY_GENERAL);
      reg  [2:0]  glitch_cnt;
      reg         act;
      reg         next_out, next_oe_n;

      // glitch window opened by owner port enable or disable transition
      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          glitch_cnt <= 3'h0;
        else if (en_edge[port])
          glitch_cnt <= glitch_len[2:0];                                        // [R6]
        else if (glitch_cnt != 3'h0)
          glitch_cnt <= glitch_cnt - 3'h1;                                      // [R11]
      end

      // activity toggle ignores link state, as the silicon does
      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          act <= 1'b0;
        else if (tx_rise[port])
          act <= ~act;                                                          // [R10]
      end

      // priority: port power-down, then reset/transition glitch, then mode
      always @*
      begin
        next_out  = 1'b0;
        next_oe_n = 1'b1;
        if (is_sdp | is_led)
        begin
          next_oe_n = 1'b0;
          if (is_led)
          begin
            if (led == `DPOC_LED_HIGH)
              next_out = 1'b1;                                                  // [R9]
            else if ((led == `DPOC_LED_MACACT) | (led == `DPOC_LED_FILTACT))
              next_out = act;                                                   // [R10]
            else
              next_out = 1'b0;                                                  // [R8]
          end
          else
            next_out = set_reg[g];                                              // [R3]
          // port-independent flag has no effect here, matching the silicon
          if (pd_s2[port])
          begin
            next_out  = 1'b1;                                                   // [R4]
            next_oe_n = ~outctl;                                                // [R4]
          end
          else if (is_sdp & ~outctl & (gr_s2 | (glitch_cnt != 3'h0)))
            next_out = 1'b0;                                                    // [R5] [R6]
        end
      end

      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          pin_out_o[g]  <= 1'b0;
          pin_oe_n_o[g] <= 1'b1;
        end
        else
        begin
          pin_out_o[g]  <= next_out;                                            // [R11]
          pin_oe_n_o[g] <= next_oe_n;
        end
      end
    end
  endgenerate

endmodule // dpoc_pin_ctrl
`default_nettype wire
